// ### bench/drive_stop_restart_sequencer_test.sv
// Purpose: self-checking bench for dss_seq over AHB-Lite
// Assumes: TICK_DIV of 10, so one 0.1 s unit is 10 cycles
// Notes:   ramp runs at 1 ms per step, so frequencies stay near zero here
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module drive_stop_restart_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TD = 10;
  localparam logic [7:0]  TA [4] = '{dss_pkg::OFS_STOP_CFG, dss_pkg::OFS_BRAKE_T,
                                     dss_pkg::OFS_DEAD_T, dss_pkg::OFS_RESTART};
  localparam logic [31:0] TE [4] = '{32'h05DC03E8, 32'h01F401F4, 32'h00008CA0,
                                     32'h00018CA0};
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp, ident_done, out_dir, out_enable, brake_active, seen;
  logic        terminal_run = 1'b0;
  logic        power_return = 1'b0;
  logic        power_fail = 1'b0;
  logic        ident_start = 1'b0;
  logic [15:0] ident_value [dss_pkg::MOTOR_PARAMS];
  logic [15:0] out_freq, brake_level, speed;
  int          fail_count = 0;
  int          checks = 0;
  int          i, n;

  always #5 hclk = ~hclk;

  dss_seq #(.TICK_DIV(TD)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .terminal_run(terminal_run), .power_return(power_return), .power_fail(power_fail),
    .ident_done(ident_done), .ident_value(ident_value), .duty_class_strap(1'b1),
    .out_freq(out_freq), .out_dir(out_dir), .out_enable(out_enable),
    .brake_level(brake_level), .brake_active(brake_active));
  dss_motor_model motor_u (.hclk(hclk), .hresetn(hresetn), .out_freq(out_freq),
    .out_enable(out_enable), .brake_active(brake_active), .ident_start(ident_start),
    .ident_done(ident_done), .ident_value(ident_value), .speed(speed));

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    `CHK(nm, e, q)
  endtask
  task automatic ticks(input int k);
    repeat (k * TD) @(posedge hclk);
  endtask
  task automatic pwr_cycle();
    power_fail <= 1'b1;
    @(posedge hclk);
    power_fail <= 1'b0;
    power_return <= 1'b1;
    @(posedge hclk);
    power_return <= 1'b0;
  endtask
  task automatic watch(input int k);
    seen = 1'b0;
    repeat (k) begin
      @(posedge hclk);
      if (brake_active === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic wait_brake(input logic lvl);
    n = 0;
    while (brake_active !== lvl && n < 200) begin
      @(posedge hclk);
      n++;
    end
  endtask
  function automatic logic [7:0] ma(input int k);
    return 8'(dss_pkg::OFS_MOTOR0 + 4 * k);
  endfunction
  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 4; i++) begin
      wr(TA[i], 32'hFFFFFFFF);
      rd_chk("clamp", TA[i], TE[i]);
    end
    wr(dss_pkg::OFS_DUTY, 32'h00000000);
    rd_chk("duty", dss_pkg::OFS_DUTY, 32'h00000001);
    for (i = 0; i < 5; i++) wr(ma(i), 32'h00000055);
    wr(dss_pkg::OFS_POWER, 32'h00000010);
    for (i = 0; i < 5; i++) rd_chk("motor_init", ma(i), 32'h00000001);
    ident_start <= 1'b1;
    @(posedge hclk);
    ident_start <= 1'b0;
    ticks(2);
    for (i = 0; i < 5; i++) rd_chk("motor_id", ma(i), 32'(32'h100 + i));
    // mode 3 is refused and the old mode kept
    wr(dss_pkg::OFS_RESTART, 32'h00000003);
    wr(dss_pkg::OFS_LIMIT, 32'h00010064);
    wr(dss_pkg::OFS_LIMIT, 32'h00030064);
    rd_chk("limit", dss_pkg::OFS_LIMIT, 32'h00010064);
    wr(dss_pkg::OFS_CMD_FREQ, 32'h00000032);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    ticks(3);
    rd_chk("below_stop", dss_pkg::OFS_CTRL, 32'h00000000);
    wr(dss_pkg::OFS_LIMIT, 32'h00000064);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    ticks(3);
    `CHK("at_limit", 1'b1, out_enable)
    wr(dss_pkg::OFS_LIMIT, 32'h00020064);
    ticks(3);
    `CHK("standby", 1'b0, out_enable)
    wr(dss_pkg::OFS_RESTART, 32'h00010003);
    pwr_cycle();
    ticks(6);
    rd_chk("standby_fail", dss_pkg::OFS_CTRL, 32'h00000000);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    wr(dss_pkg::OFS_CMD_FREQ, 32'h00000096);
    ticks(3);
    `CHK("resume", 1'b1, out_enable)
    wr(dss_pkg::OFS_CTRL, 32'h00000009);
    wr(dss_pkg::OFS_CMD_FREQ, 32'h00000032);
    ticks(3);
    `CHK("pid_no_standby", 1'b1, out_enable)
    wr(dss_pkg::OFS_LIMIT, 32'h00000000);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    pwr_cycle();
    ticks(1);
    `CHK("restart_early", 1'b0, out_enable)
    ticks(4);
    `CHK("restart_key", 1'b1, out_enable)
    wr(dss_pkg::OFS_CTRL, 32'h00000005);
    pwr_cycle();
    ticks(5);
    `CHK("term_no_run", 1'b0, out_enable)
    terminal_run <= 1'b1;
    pwr_cycle();
    ticks(5);
    `CHK("term_run", 1'b1, out_enable)
    terminal_run <= 1'b0;
    wr(dss_pkg::OFS_RESTART, 32'h00000003);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    pwr_cycle();
    ticks(5);
    rd_chk("no_restart", dss_pkg::OFS_CTRL, 32'h00000000);
    wr(dss_pkg::OFS_STOP_CFG, 32'h006403E8);
    wr(dss_pkg::OFS_BRAKE_T, 32'h00000000);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    ticks(1);
    wr(dss_pkg::OFS_CTRL, 32'h00000000);
    watch(60);
    `CHK("zero_brake", 1'b0, seen)
    `CHK("stopped", 1'b0, out_enable)
    wr(dss_pkg::OFS_BRAKE_T, 32'h00020002);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    ticks(1);
    wr(dss_pkg::OFS_CTRL, 32'h00000000);
    watch(8);
    `CHK("brake_wait", 1'b0, seen)
    wait_brake(1'b1);
    `CHK("brake_on", 1'b1, brake_active)
    `CHK("brake_level", 16'h0064, brake_level)
    wait_brake(1'b0);
    `CHK("brake_len", 1'b1, n >= 10 && n <= 21)
    `CHK("brake_end", 1'b0, out_enable)
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    ticks(1);
    wr(dss_pkg::OFS_CTRL, 32'h00000010);
    repeat (2) @(posedge hclk);
    `CHK("coast_off", 1'b0, out_enable)
    watch(60);
    `CHK("coast_brake", 1'b0, seen)
    wr(dss_pkg::OFS_DEAD_T, 32'h00000003);
    wr(dss_pkg::OFS_CTRL, 32'h00000001);
    ticks(1);
    wr(dss_pkg::OFS_CTRL, 32'h00000003);
    ticks(1);
    `CHK("dead_hold", 1'b0, out_dir)
    ticks(4);
    `CHK("dead_done", 1'b1, out_dir)
    xfer(1'b0, dss_pkg::OFS_STATUS, 32'h00000000);
    `CHK("status_dir", 1'b1, q[20])
    tally_and_finish();
  end

  initial begin
    #200_000;
    fail_count++;
    tally_and_finish();
  end
endmodule

// ### bench/dss_motor_model.sv
// Purpose: behavioural motor behind the output stage, with self-identification
// Assumes: speed follows frequency while driven
// Notes:   identified values are only valid during the done pulse
module dss_motor_model (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // output stage
  input  wire logic [15:0] out_freq,
  input  wire logic        out_enable,
  input  wire logic        brake_active,
  // self-identification
  input  wire logic        ident_start,
  output logic             ident_done,
  output logic      [15:0] ident_value [dss_pkg::MOTOR_PARAMS],
  output logic      [15:0] speed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed <= 16'h0000;
      cnt <= 4'h0;
      ident_done <= 1'b0;
    end else begin
      // coasting loses speed slowly, braking faster
      if (out_enable)
        speed <= out_freq;
      else if (speed > 16'h0003)
        speed <= speed - (brake_active ? 16'h0004 : 16'h0001);
      else
        speed <= 16'h0000;
      ident_done <= (cnt == 4'h1);
      if (ident_start)
        cnt <= 4'h8;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
  // outside the pulse the lines show junk, not the last value
  always_comb begin
    foreach (ident_value[i])
      ident_value[i] = ident_done ? 16'(16'h0100 + i) : 16'(~(16'h0100 + i));
  end
endmodule

// ### bench/dss_seq_checker.sv
// Purpose: port-level assertions for dss_seq
// Assumes: single hclk domain, async active-low reset
// Notes:   no register mirror; rules are tied to output relations
module dss_seq_checker (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  // motor stage
  input wire logic [15:0] out_freq,
  input wire logic        out_dir,
  input wire logic        out_enable,
  input wire logic [15:0] brake_level,
  input wire logic        brake_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_brake_zero_freq: assert property (brake_active |-> out_freq == 16'h0000)
    else $error("frequency output during brake");
  a_brake_end_off: assert property ($fell(brake_active) |-> !out_enable)
    else $error("output left on after brake");
  a_brake_level_idle: assert property (!brake_active |-> brake_level == 16'h0000)
    else $error("brake current without brake phase");
  a_brake_level_max: assert property (brake_active |-> brake_level <= 16'h05DC)
    else $error("brake current above range");
  a_reverse_at_zero: assert property ($changed(out_dir)
    |-> out_freq == 16'h0000 && $past(out_freq) == 16'h0000)
    else $error("direction changed at speed");
  a_ramp_step: assert property (out_enable && $past(out_enable) && !brake_active
    && out_freq < $past(out_freq) |-> $past(out_freq) - out_freq == 16'h0001)
    else $error("ramp step size wrong");
  a_off_zero_freq: assert property (!out_enable && !brake_active
    |-> out_freq == 16'h0000) else $error("frequency with output off");
endmodule

bind dss_seq dss_seq_checker chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .out_freq(out_freq), .out_dir(out_dir),
  .out_enable(out_enable), .brake_level(brake_level), .brake_active(brake_active));

// ### logic/dss_pkg.sv
// Purpose: shared constants for the stop/restart sequencer
// Assumes: 100 MHz hclk, AHB-Lite register access
// Notes:   times are set in 0.1 s units, frequencies in 0.01 Hz units
package dss_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STOP_CFG  = 8'h04;
  localparam logic [7:0] OFS_BRAKE_T   = 8'h08;
  localparam logic [7:0] OFS_DEAD_T    = 8'h0C;
  localparam logic [7:0] OFS_LIMIT     = 8'h10;
  localparam logic [7:0] OFS_RESTART   = 8'h14;
  localparam logic [7:0] OFS_CMD_FREQ  = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_DUTY      = 8'h20;
  localparam logic [7:0] OFS_POWER     = 8'h24;
  localparam logic [7:0] OFS_MOTOR0    = 8'h28;
  localparam int         MOTOR_PARAMS  = 5;
  // field positions
  localparam int CTRL_RUN_POS    = 0;
  localparam int CTRL_DIR_POS    = 1;
  localparam int CTRL_SRC_POS    = 2;
  localparam int CTRL_PID_POS    = 3;
  localparam int CTRL_STOPM_POS  = 4;
  localparam int LIMIT_MODE_POS  = 16;
  localparam int RST_EN_POS      = 16;
  localparam int BRAKE_WAIT_POS  = 16;
  localparam int STOP_CUR_POS    = 16;
  // limits and resets
  localparam logic [15:0] BRAKE_FREQ_MAX = 16'h03E8;
  localparam logic [15:0] BRAKE_TIME_MAX = 16'h01F4;
  localparam logic [15:0] LONG_TIME_MAX  = 16'h8CA0;
  localparam logic [15:0] CURRENT_MAX    = 16'h05DC;
  localparam logic [15:0] DEFAULT_MOTOR  = 16'h0001;
  localparam logic [15:0] DECEL_STEP     = 16'h0001;
  // timing: one tick per 0.1 s
  localparam int CLK_HZ        = 100_000_000;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int DECEL_MS      = 1;
  localparam int DECEL_CYCLES  = CLK_HZ / 1000 * DECEL_MS;

  typedef enum logic [1:0] { UL_RUN_AT_LIMIT, UL_STOP, UL_STANDBY } dss_under_t;

  function automatic logic [15:0] dss_clamp(input logic [15:0] v, input logic [15:0] mx);
    dss_clamp = (v > mx) ? mx : v;
  endfunction
endpackage

// ### logic/dss_seq.sv
// Purpose: stop, brake, reversal, lower-limit and power-return sequencing of a drive
// Assumes: AHB-Lite single word transfers; motor stage takes frequency and brake level
// Notes:   ramp is linear, one 0.01 Hz step per step enable
module dss_seq #(
  parameter int TICK_DIV = dss_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // commands and events
  input  wire logic        terminal_run,
  input  wire logic        power_return,
  input  wire logic        power_fail,
  input  wire logic        ident_done,
  input  wire logic [15:0] ident_value [dss_pkg::MOTOR_PARAMS],
  input  wire logic        duty_class_strap,
  // motor output stage
  output logic      [15:0] out_freq,
  output logic             out_dir,
  output logic             out_enable,
  output logic      [15:0] brake_level,
  output logic             brake_active
);
  typedef enum logic [2:0] { ST_STOPPED, ST_RUN, ST_DECEL, ST_WAIT, ST_BRAKE,
                             ST_DEAD, ST_STANDBY, ST_RESTART } dss_state_t;

  typedef struct packed {
    dss_state_t  st;
    logic        run;
    logic        dir;
    logic        src_term;
    logic        pid;
    logic        stop_coast;
    logic [15:0] brk_freq;
    logic [15:0] brk_cur;
    logic [15:0] brk_wait;
    logic [15:0] brk_time;
    logic [15:0] dead_time;
    logic [15:0] low_limit;
    logic [1:0]  ul_mode;
    logic        rst_en;
    logic [15:0] rst_delay;
    logic [15:0] cmd_freq;
    logic [15:0] power;
    logic [79:0] motor;
    logic        duty;
    logic        duty_loaded;
    logic [15:0] freq;
    logic        cur_dir;
    logic [15:0] tcnt;
    logic        down_standby;
    logic        a_wr;
    logic        a_rd;
    logic [7:0]  a_addr;
    logic [31:0] rdata;
  } dss_seq_s_t;

  dss_seq_s_t s_reg, s_next;
  dss_tick_if tk();

  // only the 0.1 s base is scaled for simulation; the ramp rate stays fixed
  dss_tick_gen #(.TICK_DIV(TICK_DIV), .STEP_DIV(dss_pkg::DECEL_CYCLES)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tk      (tk.src)
  );

  // lower-limit handling is off while the limit is zero
  function automatic logic [15:0] target_freq(input dss_seq_s_t s, output logic below);
    below = (s.low_limit != 16'h0000) && (s.cmd_freq < s.low_limit);
    target_freq = below ? s.low_limit : s.cmd_freq;
  endfunction

  logic        a_take;
  logic [15:0] tgt;
  logic        below;
  logic        want_run;
  logic [31:0] rd_mux;

  assign a_take = hsel && hready && htrans[1];

  // read data is registered in the data phase, which costs one wait state
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_reg.a_addr)
      dss_pkg::OFS_CTRL:     rd_mux = {27'h0, s_reg.stop_coast, s_reg.pid, s_reg.src_term,
                                       s_reg.dir, s_reg.run};
      dss_pkg::OFS_STOP_CFG: rd_mux = {s_reg.brk_cur, s_reg.brk_freq};
      dss_pkg::OFS_BRAKE_T:  rd_mux = {s_reg.brk_wait, s_reg.brk_time};
      dss_pkg::OFS_DEAD_T:   rd_mux = {16'h0, s_reg.dead_time};
      dss_pkg::OFS_LIMIT:    rd_mux = {14'h0, s_reg.ul_mode, s_reg.low_limit};
      dss_pkg::OFS_RESTART:  rd_mux = {15'h0, s_reg.rst_en, s_reg.rst_delay};
      dss_pkg::OFS_CMD_FREQ: rd_mux = {16'h0, s_reg.cmd_freq};
      dss_pkg::OFS_STATUS:   rd_mux = {11'h0, s_reg.cur_dir, 1'b0, s_reg.st,
                                       s_reg.freq};
      dss_pkg::OFS_DUTY:     rd_mux = {31'h0, s_reg.duty};
      dss_pkg::OFS_POWER:    rd_mux = {16'h0, s_reg.power};
      default: begin
        for (int i = 0; i < dss_pkg::MOTOR_PARAMS; i++) begin
          if (s_reg.a_addr == 8'(dss_pkg::OFS_MOTOR0 + 4 * i)) begin
            rd_mux = {16'h0, s_reg.motor[i*16 +: 16]};
          end
        end
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    tgt = target_freq(s_reg, below);
    want_run = s_reg.run;
    // bus: address phase latch, data phase act
    s_next.a_wr = a_take && hwrite;
    s_next.a_rd = a_take && !hwrite;
    if (a_take) begin
      s_next.a_addr = haddr;
    end
    if (s_reg.a_rd) begin
      s_next.rdata = rd_mux;
    end
    if (!s_reg.duty_loaded) begin
      s_next.duty = duty_class_strap;
      s_next.duty_loaded = 1'b1;
    end
    // out-of-range time and stop settings saturate at their maximum instead of wrapping; limit mode 3 is refused
    if (s_reg.a_wr) begin
      unique case (s_reg.a_addr)
        dss_pkg::OFS_CTRL: begin
          s_next.run        = hwdata[dss_pkg::CTRL_RUN_POS];
          s_next.dir        = hwdata[dss_pkg::CTRL_DIR_POS];
          s_next.src_term   = hwdata[dss_pkg::CTRL_SRC_POS];
          s_next.pid        = hwdata[dss_pkg::CTRL_PID_POS];
          s_next.stop_coast = hwdata[dss_pkg::CTRL_STOPM_POS];
        end
        dss_pkg::OFS_STOP_CFG: begin
          s_next.brk_freq = dss_pkg::dss_clamp(hwdata[15:0], dss_pkg::BRAKE_FREQ_MAX);
          s_next.brk_cur  = dss_pkg::dss_clamp(hwdata[dss_pkg::STOP_CUR_POS +: 16],
                                               dss_pkg::CURRENT_MAX);
        end
        dss_pkg::OFS_BRAKE_T: begin
          s_next.brk_time = dss_pkg::dss_clamp(hwdata[15:0], dss_pkg::BRAKE_TIME_MAX);
          s_next.brk_wait = dss_pkg::dss_clamp(hwdata[dss_pkg::BRAKE_WAIT_POS +: 16],
                                               dss_pkg::BRAKE_TIME_MAX);
        end
        dss_pkg::OFS_DEAD_T:
          s_next.dead_time = dss_pkg::dss_clamp(hwdata[15:0], dss_pkg::LONG_TIME_MAX);
        dss_pkg::OFS_LIMIT: begin
          s_next.low_limit = hwdata[15:0];
          if (hwdata[dss_pkg::LIMIT_MODE_POS +: 2] != 2'h3) begin
            s_next.ul_mode = hwdata[dss_pkg::LIMIT_MODE_POS +: 2];
          end
        end
        dss_pkg::OFS_RESTART: begin
          s_next.rst_delay = dss_pkg::dss_clamp(hwdata[15:0], dss_pkg::LONG_TIME_MAX);
          s_next.rst_en    = hwdata[dss_pkg::RST_EN_POS];
        end
        dss_pkg::OFS_CMD_FREQ: s_next.cmd_freq = hwdata[15:0];
        dss_pkg::OFS_DUTY: ; // read-only model class
        dss_pkg::OFS_POWER: begin
          s_next.power = hwdata[15:0];
          s_next.motor = {dss_pkg::MOTOR_PARAMS{dss_pkg::DEFAULT_MOTOR}};
        end
        default: begin
          for (int i = 0; i < dss_pkg::MOTOR_PARAMS; i++) begin
            if (s_reg.a_addr == 8'(dss_pkg::OFS_MOTOR0 + 4 * i)) begin
              s_next.motor[i*16 +: 16] = hwdata[15:0];
            end
          end
        end
      endcase
    end
    if (ident_done) begin
      for (int i = 0; i < dss_pkg::MOTOR_PARAMS; i++) begin
        s_next.motor[i*16 +: 16] = ident_value[i];
      end
    end
    // one shared down-counter serves the wait, brake, dead and restart delays
    if (tk.tick && s_reg.tcnt != 16'h0000) begin
      s_next.tcnt = s_reg.tcnt - 16'h1;
    end
    // sequencing
    unique case (s_reg.st)
      ST_STOPPED: begin
        s_next.freq = '0;
        if (want_run && below && s_reg.ul_mode == 2'(dss_pkg::UL_STOP)) begin
          // a refused start drops the command so a later setpoint rise cannot start it
          s_next.run = 1'b0;
        end else if (want_run && below && s_reg.ul_mode == 2'(dss_pkg::UL_STANDBY)
                     && !s_reg.pid) begin
          s_next.st = ST_STANDBY;
        end else if (want_run) begin
          s_next.cur_dir = s_reg.dir;
          s_next.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!want_run || (below && s_reg.ul_mode == 2'(dss_pkg::UL_STOP))) begin
          if (!want_run && s_reg.stop_coast) begin
            s_next.freq = '0;
            s_next.st = ST_STOPPED;
          end else begin
            s_next.st = ST_DECEL;
          end
          if (!want_run) begin
            s_next.run = s_reg.run;
          end
          if (below) begin
            s_next.run = 1'b0;
          end
        end else if (below && s_reg.ul_mode == 2'(dss_pkg::UL_STANDBY) && !s_reg.pid) begin
          s_next.freq = '0;
          s_next.st = ST_STANDBY;
        end else if (s_reg.dir != s_reg.cur_dir) begin
          // reverse only through zero so the stage never flips direction at speed
          if (s_reg.freq == 16'h0000) begin
            s_next.tcnt = s_reg.dead_time;
            s_next.st = ST_DEAD;
          end else if (tk.step) begin
            s_next.freq = s_reg.freq - dss_pkg::DECEL_STEP;
          end
        end else if (tk.step) begin
          if (s_reg.freq < tgt) begin
            s_next.freq = s_reg.freq + dss_pkg::DECEL_STEP;
          end else if (s_reg.freq > tgt) begin
            s_next.freq = s_reg.freq - dss_pkg::DECEL_STEP;
          end
        end
      end
      ST_DECEL: begin
        if (want_run && !below) begin
          s_next.st = ST_RUN;
        end else if (s_reg.brk_time != 16'h0000 && s_reg.freq <= s_reg.brk_freq) begin
          s_next.tcnt = s_reg.brk_wait;
          // output is blocked through the wait, so no frequency may stand
          s_next.freq = '0;
          s_next.st = ST_WAIT;
        end else if (s_reg.freq == 16'h0000) begin
          s_next.st = ST_STOPPED;
        end else if (tk.step) begin
          s_next.freq = s_reg.freq - dss_pkg::DECEL_STEP;
        end
      end
      ST_WAIT: begin
        if (s_reg.tcnt == 16'h0000) begin
          s_next.tcnt = s_reg.brk_time;
          s_next.st = ST_BRAKE;
        end
      end
      ST_BRAKE: begin
        if (s_reg.tcnt == 16'h0000) begin
          s_next.freq = '0;
          s_next.st = ST_STOPPED;
        end
      end
      ST_DEAD: begin
        if (s_reg.tcnt == 16'h0000) begin
          s_next.cur_dir = s_reg.dir;
          s_next.st = ST_RUN;
        end
      end
      ST_STANDBY: begin
        if (!want_run) begin
          s_next.st = ST_STOPPED;
        end else if (!below || s_reg.pid) begin
          s_next.st = ST_RUN;
        end
      end
      ST_RESTART: begin
        if (s_reg.tcnt == 16'h0000) begin
          if (!s_reg.src_term || terminal_run) begin
            s_next.run = 1'b1;
            s_next.st = ST_STOPPED;
          end
        end
      end
      default: s_next.st = ST_STOPPED;
    endcase
    // power loss wins over every state; a drop in standby bars the restart
    if (power_fail) begin
      s_next.down_standby = (s_reg.st == ST_STANDBY);
      s_next.freq = '0;
      s_next.st = ST_STOPPED;
      s_next.run = 1'b0;
    end else if (power_return) begin
      if (s_reg.rst_en && !s_reg.down_standby) begin
        s_next.tcnt = s_reg.rst_delay;
        s_next.st = ST_RESTART;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // writes take no wait state; a read answer is ready one cycle after the data phase
  assign hreadyout    = !s_reg.a_rd;
  assign hresp        = 1'b0;
  assign hrdata       = s_reg.rdata;
  assign out_freq     = s_reg.freq;
  assign out_dir      = s_reg.cur_dir;
  assign out_enable   = (s_reg.st == ST_RUN) || (s_reg.st == ST_DECEL) ||
                        (s_reg.st == ST_DEAD) || (s_reg.st == ST_BRAKE);
  assign brake_active = (s_reg.st == ST_BRAKE);
  assign brake_level  = (s_reg.st == ST_BRAKE) ? s_reg.brk_cur : 16'h0000;
endmodule

// ### logic/dss_tick_gen.sv
// Purpose: derives 0.1 s tick and ramp-step enables from hclk
// Assumes: 100 MHz clock
// Notes:   counts are package constants; the tick period is a parameter for simulation
module dss_tick_gen #(
  parameter int TICK_DIV = dss_pkg::TICK_CYCLES,
  parameter int STEP_DIV = dss_pkg::DECEL_CYCLES
) (
  // clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // enables
  dss_tick_if.src    tk
);
  typedef struct packed {
    logic [31:0] tcnt;
    logic [31:0] scnt;
    logic        tick;
    logic        step;
  } dss_tg_t;
  dss_tg_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    s_next.step = 1'b0;
    if (s_reg.tcnt >= 32'(TICK_DIV - 1)) begin
      s_next.tcnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.tcnt = s_reg.tcnt + 32'h1;
    end
    if (s_reg.scnt >= 32'(STEP_DIV - 1)) begin
      s_next.scnt = '0;
      s_next.step = 1'b1;
    end else begin
      s_next.scnt = s_reg.scnt + 32'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tk.tick = s_reg.tick;
  assign tk.step = s_reg.step;
endmodule

// ### logic/dss_tick_if.sv
// Purpose: carries the time-base pulses from divider to sequencer
// Assumes: single hclk domain
// Notes:   pulses last one cycle
interface dss_tick_if;
  logic tick;
  logic step;
  modport src (output tick, output step);
  modport dst (input tick, input step);
endinterface
